// [bie_defs.svh]
`ifndef BIE_DEFS_SVH
`define BIE_DEFS_SVH
// ==========================================
// opcode patterns
`define BIE_BRANCH_W1_OP 8'hef
`define BIE_BRANCH_W2_OP 4'hf
`define BIE_INC_OP 6'h0a
// ==========================================
// field positions within an instruction word
`define BIE_INC_D_BIT 9
`define BIE_INC_A_BIT 8
// ==========================================
// addressing limits and widths
`define BIE_IDX_LIMIT 8'h5f
`define BIE_ACCESS_SPLIT 8'h60
`define BIE_DADDR_W 12
// ==========================================
// status bit positions
`define BIE_FLAG_C 0
`define BIE_FLAG_DC 1
`define BIE_FLAG_Z 2
`define BIE_FLAG_OV 3
`define BIE_FLAG_N 4
// ==========================================
// phases per instruction cycle
`define BIE_PHASE_CNT 4
`endif

// [bie_exec.sv]
`include "bie_defs.svh"
// What this block does
// [RULE1] the long branch loads its 20-bit literal into pc bits 20..1.
// [RULE2] the branch is word ef/kk then f/kkk, low literal byte first.
// [RULE3] the branch takes two cycles, the second a nop, no flag changes.
// [RULE4] the increment 0010_10da ffff_ffff adds one, sets c dc n ov z.
// [RULE5] d=0 writes the accumulator, d=1 writes back to the register.
// [RULE6] a=0 uses the access bank, a=1 uses bank_select_reg.
// [RULE7] a=0, extended set on and f<=95 uses indexed literal offset.
module bie_exec (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic ext_set_en_i,
  input wire logic [3:0] bank_select_reg_i,
  input wire logic [11:0] index_base_i,
  input wire logic [7:0] rd_data_i,
  input wire logic [7:0] acc_i,
  input wire logic [4:0] status_i,
  output logic [20:0] pc_o,
  output logic pc_load_o,
  output logic [11:0] rd_addr_o,
  output logic rd_en_o,
  output logic [11:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  output logic wr_en_o,
  output logic [7:0] acc_o,
  output logic acc_we_o,
  output logic [4:0] status_o,
  output logic status_we_o,
  output logic busy_o
);

  // ==========================================
  // operand address
  function automatic logic [11:0] bie_addr(input logic [7:0] f,
    input logic a, input logic ext, input logic [3:0] bank,
    input logic [11:0] base);
    logic [11:0] r;
    r = 12'h000;
    if (a) begin
      r = {bank, f}; // [RULE6]
    end else if (ext && f <= `BIE_IDX_LIMIT) begin
      r = base + {4'h0, f}; // [RULE7]
    end else if (f < `BIE_ACCESS_SPLIT) begin
      r = {4'h0, f}; // [RULE6]
    end else begin
      r = {4'hf, f};
    end
    return r;
  endfunction : bie_addr

  // ==========================================
  // state
  bie_pkg::bie_state_e state_ff, nxt_state;
  bie_pkg::bie_phase_t phase_ff, nxt_phase;
  logic [7:0] klo_ff, nxt_klo;
  logic inc_d_ff, nxt_inc_d;
  logic inc_go_ff, nxt_inc_go;
  logic [11:0] inc_addr_ff, nxt_inc_addr;
  logic [20:0] pc_ff, nxt_pc;
  logic pc_load_ff, nxt_pc_load;
  logic [11:0] rd_addr_ff, nxt_rd_addr;
  logic rd_en_ff, nxt_rd_en;
  logic [11:0] wr_addr_ff, nxt_wr_addr;
  logic [7:0] wr_data_ff, nxt_wr_data;
  logic wr_en_ff, nxt_wr_en;
  logic [7:0] acc_ff, nxt_acc;
  logic acc_we_ff, nxt_acc_we;
  logic [7:0] acc_out_ff, nxt_acc_out;
  logic busy_ff, nxt_busy;
  logic [4:0] status_ff, nxt_status;
  logic status_we_ff, nxt_status_we;

  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] res;
  logic is_br1;
  logic is_inc;
  logic [11:0] addr;

  always_comb begin
    sum = {1'b0, rd_data_i} + 9'h001; // [RULE4]
    nib = {1'b0, rd_data_i[3:0]} + 5'h01;
    res = sum[7:0];
    is_br1 = instr_valid_i && instr_i[15:8] == `BIE_BRANCH_W1_OP; // [RULE2]
    is_inc = instr_valid_i && instr_i[15:10] == `BIE_INC_OP; // [RULE4]
    addr = bie_addr(instr_i[7:0], instr_i[`BIE_INC_A_BIT], ext_set_en_i,
      bank_select_reg_i, index_base_i);
  end

  // ==========================================
  // next values
  always_comb begin
    nxt_state = state_ff;
    nxt_phase = phase_ff + 2'h1;
    nxt_klo = klo_ff;
    nxt_inc_d = inc_d_ff;
    nxt_inc_go = inc_go_ff;
    nxt_inc_addr = inc_addr_ff;
    nxt_pc = pc_ff;
    nxt_pc_load = 1'b0;
    nxt_rd_addr = rd_addr_ff;
    nxt_rd_en = 1'b0;
    nxt_wr_addr = wr_addr_ff;
    nxt_wr_data = wr_data_ff;
    nxt_wr_en = 1'b0;
    nxt_acc = acc_ff;
    nxt_acc_we = 1'b0;
    // flags and accumulator echo their live inputs unless written
    nxt_status = status_i;
    nxt_status_we = 1'b0;
    nxt_acc_out = acc_i;
    case (phase_ff)
      2'h0: begin
        // q1: decode
        nxt_inc_go = 1'b0;
        case (state_ff)
          bie_pkg::BIE_IDLE: begin
            if (is_br1) begin
              nxt_klo = instr_i[7:0]; // [RULE2]
              nxt_state = bie_pkg::BIE_BR2;
            end else if (is_inc) begin
              nxt_inc_go = 1'b1;
              nxt_inc_d = instr_i[`BIE_INC_D_BIT];
              nxt_inc_addr = addr;
            end
          end
          bie_pkg::BIE_BR2: begin
            // second word only completes a real branch
            if (instr_valid_i &&
                instr_i[15:12] == `BIE_BRANCH_W2_OP) begin // [RULE2]
              nxt_state = bie_pkg::BIE_FLUSH;
            end else begin
              nxt_state = bie_pkg::BIE_IDLE;
            end
          end
          bie_pkg::BIE_FLUSH: begin
            nxt_state = bie_pkg::BIE_IDLE; // [RULE3]
          end
          default: nxt_state = bie_pkg::BIE_IDLE;
        endcase
      end
      2'h1: begin
        // q2: read operand
        if (inc_go_ff) begin
          nxt_rd_addr = inc_addr_ff;
          nxt_rd_en = 1'b1;
        end
      end
      2'h2: begin
        // q3: process, data returns this phase
        if (inc_go_ff) begin
          nxt_status[`BIE_FLAG_C] = sum[8]; // [RULE4]
          nxt_status[`BIE_FLAG_DC] = nib[4];
          nxt_status[`BIE_FLAG_Z] = res == 8'h00;
          nxt_status[`BIE_FLAG_N] = res[7];
          nxt_status[`BIE_FLAG_OV] = rd_data_i == 8'h7f;
          nxt_status_we = 1'b1;
          if (inc_d_ff) begin
            nxt_wr_addr = inc_addr_ff; // [RULE5]
            nxt_wr_data = res;
          end else begin
            nxt_acc = res; // [RULE5]
          end
        end
      end
      default: begin
        // q4: write result or program counter
        if (inc_go_ff) begin
          nxt_wr_en = inc_d_ff; // [RULE5]
          nxt_acc_we = ~inc_d_ff;
          if (!inc_d_ff) begin
            nxt_acc_out = acc_ff; // [RULE5]
          end
        end
        if (state_ff == bie_pkg::BIE_FLUSH) begin
          nxt_pc = {instr_i[11:0], klo_ff, 1'b0}; // [RULE1]
          nxt_pc_load = 1'b1;
        end
      end
    endcase
    nxt_busy = nxt_state != bie_pkg::BIE_IDLE; // [RULE3]
  end

  // ==========================================
  // registers
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_ff <= bie_pkg::BIE_IDLE;
      phase_ff <= 2'h0;
      klo_ff <= 8'h00;
      inc_d_ff <= 1'b0;
      inc_go_ff <= 1'b0;
      inc_addr_ff <= 12'h000;
      pc_ff <= 21'h000000;
      pc_load_ff <= 1'b0;
      rd_addr_ff <= 12'h000;
      rd_en_ff <= 1'b0;
      wr_addr_ff <= 12'h000;
      wr_data_ff <= 8'h00;
      wr_en_ff <= 1'b0;
      acc_ff <= 8'h00;
      acc_we_ff <= 1'b0;
      acc_out_ff <= 8'h00;
      busy_ff <= 1'b0;
      status_ff <= 5'h00;
      status_we_ff <= 1'b0;
    end else if (clk_en_i) begin
      state_ff <= nxt_state;
      phase_ff <= nxt_phase;
      klo_ff <= nxt_klo;
      inc_d_ff <= nxt_inc_d;
      inc_go_ff <= nxt_inc_go;
      inc_addr_ff <= nxt_inc_addr;
      pc_ff <= nxt_pc;
      pc_load_ff <= nxt_pc_load;
      rd_addr_ff <= nxt_rd_addr;
      rd_en_ff <= nxt_rd_en;
      wr_addr_ff <= nxt_wr_addr;
      wr_data_ff <= nxt_wr_data;
      wr_en_ff <= nxt_wr_en;
      acc_ff <= nxt_acc;
      acc_we_ff <= nxt_acc_we;
      acc_out_ff <= nxt_acc_out;
      busy_ff <= nxt_busy;
      status_ff <= nxt_status;
      status_we_ff <= nxt_status_we;
    end
  end

  assign status_o = status_ff;
  assign pc_o = pc_ff;
  assign pc_load_o = pc_load_ff;
  assign rd_addr_o = rd_addr_ff;
  assign rd_en_o = rd_en_ff;
  assign wr_addr_o = wr_addr_ff;
  assign wr_data_o = wr_data_ff;
  assign wr_en_o = wr_en_ff;
  assign acc_o = acc_out_ff;
  assign acc_we_o = acc_we_ff;
  assign status_we_o = status_we_ff;
  assign busy_o = busy_ff;

endmodule : bie_exec

// [bie_exec_properties.sv]
module bie_exec_properties (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] rd_data_i,
  input wire logic [20:0] pc_o,
  input wire logic pc_load_o,
  input wire logic [11:0] rd_addr_o,
  input wire logic rd_en_o,
  input wire logic [11:0] wr_addr_o,
  input wire logic [7:0] wr_data_o,
  input wire logic wr_en_o,
  input wire logic [7:0] acc_o,
  input wire logic acc_we_o,
  input wire logic [4:0] status_o,
  input wire logic status_we_o,
  input wire logic busy_o
);
  // ==========================================
  // increment and branch checks
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  read_then_flags_a: assert property (rd_en_o |=> status_we_o)
    else $error("flags not written after read");
  one_dest_a: assert property (rd_en_o |-> ##2 (wr_en_o ^ acc_we_o))
    else $error("not exactly one destination");
  wr_sum_a: assert property (wr_en_o |->
    wr_data_o == 8'($past(rd_data_i, 2) + 8'h01)) else $error("bad wr data");
  acc_sum_a: assert property (acc_we_o |->
    acc_o == 8'($past(rd_data_i, 2) + 8'h01)) else $error("bad acc data");
  wr_same_addr_a: assert property (wr_en_o |->
    wr_addr_o == $past(rd_addr_o, 2)) else $error("write addr differs");
  zero_flag_a: assert property (status_we_o |->
    status_o[2] == ($past(rd_data_i) == 8'hff)) else $error("bad zero");
  carry_flag_a: assert property (status_we_o |->
    status_o[0] == ($past(rd_data_i) == 8'hff)) else $error("bad carry");
  branch_quiet_a: assert property (busy_o |-> !status_we_o)
    else $error("flags written in branch");
  pc_even_a: assert property (pc_load_o |-> !pc_o[0])
    else $error("pc bit 0 set");
endmodule : bie_exec_properties

bind bie_exec bie_exec_properties u_chk (.ref_clk_i, .rst_i, .rd_data_i,
  .pc_o, .pc_load_o, .rd_addr_o, .rd_en_o, .wr_addr_o, .wr_data_o, .wr_en_o,
  .acc_o, .acc_we_o, .status_o, .status_we_o, .busy_o);

// [bie_exec_tb_top.sv]
module bie_exec_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i, rst_i, clk_en_i, instr_valid_i, ext_set_en_i;
  logic pc_load_o, rd_en_o, wr_en_o, acc_we_o, status_we_o, busy_o;
  logic [15:0] instr_i;
  logic [3:0] bank_select_reg_i;
  logic [11:0] index_base_i, rd_addr_o, wr_addr_o;
  logic [7:0] rd_data_i, acc_i, wr_data_o, acc_o;
  logic [4:0] status_i, status_o;
  logic [20:0] pc_o;
  logic [1:0] ph;
  int failures, checks_done;
  bie_exec u_dut (.ref_clk_i, .rst_i, .clk_en_i, .instr_valid_i, .instr_i,
    .ext_set_en_i, .bank_select_reg_i, .index_base_i, .rd_data_i, .acc_i,
    .status_i, .pc_o, .pc_load_o, .rd_addr_o, .rd_en_o, .wr_addr_o,
    .wr_data_o, .wr_en_o, .acc_o, .acc_we_o, .status_o, .status_we_o,
    .busy_o);
  // ==========================================
  // helpers
  always @(posedge ref_clk_i) ph <= rst_i ? 2'h0 : ph + 2'h1;
  task automatic test_done();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [20:0] g, input logic [20:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // drive on the edge before a phase 0 edge
  task automatic sync();
    int n;
    for (n = 0; n < 8; n++) begin
      @(posedge ref_clk_i);
      if (ph === 2'h3) return;
    end
    failures++;
    test_done();
  endtask : sync
  task automatic run_inc(input logic [15:0] w, input logic [7:0] rd,
      input logic [11:0] ea, input logic d, input logic x);
    logic [7:0] r;
    r = rd + 8'h01;
    sync();
    instr_i <= w;
    instr_valid_i <= 1'b1;
    rd_data_i <= rd;
    ext_set_en_i <= x;
    @(posedge ref_clk_i);
    instr_valid_i <= 1'b0;
    @(negedge ref_clk_i);
    @(negedge ref_clk_i);
    chk(rd_en_o, 1'b1);
    chk(rd_addr_o, ea);
    @(negedge ref_clk_i);
    chk(status_o, {r[7], r == 8'h80, r == 8'h00, rd[3:0] == 4'hf,
      rd == 8'hff});
    @(negedge ref_clk_i);
    chk(wr_en_o, d);
    chk(acc_we_o, !d);
    chk(d ? wr_data_o : acc_o, r);
    if (d) chk(wr_addr_o, ea);
    @(negedge ref_clk_i);
    chk(status_o, status_i);
    chk(acc_o, acc_i);
  endtask : run_inc
  // ==========================================
  // scenarios
  task automatic t_inc_dest();
    run_inc(16'h2a10, 8'hff, 12'h010, 1'b1, 1'b0);
    run_inc(16'h2880, 8'h7f, 12'hf80, 1'b0, 1'b0);
    $display("dest test done");
  endtask : t_inc_dest
  task automatic t_inc_bank();
    run_inc(16'h2b22, 8'h0e, 12'h322, 1'b1, 1'b1);
    $display("bank test done");
  endtask : t_inc_bank
  task automatic t_inc_index();
    run_inc(16'h2a5f, 8'h41, 12'h25f, 1'b1, 1'b1);
    run_inc(16'h2a60, 8'h00, 12'hf60, 1'b1, 1'b1);
    run_inc(16'h2a05, 8'h10, 12'h005, 1'b1, 1'b0);
    $display("index test done");
  endtask : t_inc_index
  task automatic t_branch();
    int i;
    sync();
    instr_i <= 16'hefde;
    instr_valid_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    instr_i <= 16'hfabc;
    @(negedge ref_clk_i);
    chk(busy_o, 1'b1);
    for (i = 0; i < 16 && pc_load_o !== 1'b1; i++) begin
      @(negedge ref_clk_i);
      chk(status_we_o, 1'b0);
    end
    if (pc_load_o !== 1'b1) begin
      failures++;
      test_done();
    end
    chk(pc_o, 21'h1579bc);
    $display("branch test done");
  endtask : t_branch
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    rst_i = 1'b1;
    clk_en_i = 1'b1;
    instr_valid_i = 1'b0;
    instr_i = 16'h0000;
    ext_set_en_i = 1'b0;
    bank_select_reg_i = 4'h3;
    index_base_i = 12'h200;
    rd_data_i = 8'h00;
    acc_i = 8'h5a;
    status_i = 5'h15;
    failures = 0;
    checks_done = 0;
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_inc_dest();
    t_inc_bank();
    t_inc_index();
    t_branch();
    t_inc_dest();
    test_done();
  end
endmodule : bie_exec_tb_top

// [bie_pkg.sv]
package bie_pkg;
  typedef enum logic [1:0] {
    BIE_IDLE = 2'b00,
    BIE_BR2 = 2'b01,
    BIE_FLUSH = 2'b11
  } bie_state_e;
  typedef logic [1:0] bie_phase_t;
endpackage : bie_pkg
